// File: common/cct_pkg.sv
// Constants, field layouts and types of the calendar clock with second trim
package cct_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [15:0] ADDR_SEC = 16'h2015;
  localparam logic [15:0] ADDR_MIN = 16'h2016;
  localparam logic [15:0] ADDR_HR = 16'h2017;
  localparam logic [15:0] ADDR_WDAY = 16'h2018;
  localparam logic [15:0] ADDR_DATE = 16'h2019;
  localparam logic [15:0] ADDR_MO = 16'h201A;
  localparam logic [15:0] ADDR_YR = 16'h201B;
  localparam logic [15:0] ADDR_TRIM = 16'h201C;

  // ==========================================================================
  // Field positions and widths
  localparam int TRIM_INC_BIT = 0;
  localparam int TRIM_DEC_BIT = 1;
  localparam int SEC_W = 6;
  localparam int MIN_W = 6;
  localparam int HR_W = 5;
  localparam int WDAY_W = 3;
  localparam int DATE_W = 5;
  localparam int MO_W = 4;
  localparam int YR_W = 8;

  // ==========================================================================
  // Count limits and month codes
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HR_MAX = 5'h17;
  localparam logic [2:0] WDAY_MIN = 3'h1;
  localparam logic [2:0] WDAY_MAX = 3'h7;
  localparam logic [4:0] DATE_MIN = 5'h01;
  localparam logic [3:0] MO_MIN = 4'h1;
  localparam logic [3:0] MO_MAX = 4'hC;
  localparam logic [3:0] MO_FEB = 4'h2;
  localparam logic [3:0] MO_APR = 4'h4;
  localparam logic [3:0] MO_JUN = 4'h6;
  localparam logic [3:0] MO_SEP = 4'h9;
  localparam logic [3:0] MO_NOV = 4'hB;
  localparam logic [4:0] LEN_31 = 5'h1F;
  localparam logic [4:0] LEN_30 = 5'h1E;
  localparam logic [4:0] LEN_29 = 5'h1D;
  localparam logic [4:0] LEN_28 = 5'h1C;

  // ==========================================================================
  // Reset values
  localparam logic [5:0] RST_SEC = 6'h00;
  localparam logic [5:0] RST_MIN = 6'h00;
  localparam logic [4:0] RST_HR = 5'h00;
  localparam logic [2:0] RST_WDAY = 3'h1;
  localparam logic [4:0] RST_DATE = 5'h01;
  localparam logic [3:0] RST_MO = 4'h1;
  localparam logic [7:0] RST_YR = 8'h00;

  // ==========================================================================
  // Timing
  localparam int SECOND_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES_DFLT = SECOND_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [YR_W-1:0] yr;
    logic [MO_W-1:0] mo;
    logic [DATE_W-1:0] date;
    logic [WDAY_W-1:0] wday;
    logic [HR_W-1:0] hr;
    logic [MIN_W-1:0] min;
    logic [SEC_W-1:0] sec;
  } cct_time_t;

  typedef enum logic [2:0] {
    CCT_TRIM_IDLE = 3'b001,
    CCT_TRIM_UP = 3'b010,
    CCT_TRIM_DN = 3'b100
  } cct_trim_state_t;

endpackage

// File: common/cct_tick_if.sv
// Seconds tick carried from the timebase divider to the calendar logic
interface cct_tick_if;
  logic tick;
  modport gen (output tick);
  modport user (input tick);
endinterface

// File: src/cct_tick_gen.sv
// Timebase divider that makes a one-cycle seconds tick from the core clock
module cct_tick_gen
  import cct_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input wire logic core_clk,
  input wire logic rst,
  cct_tick_if.gen tickBus
);

  localparam int CNT_W = $clog2(TICK_CYCLES);

  logic [CNT_W-1:0] count_reg;
  logic tick_reg;

  // ==========================================================================
  // Divider: wraps once per second and pulses the tick
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else if (count_reg == CNT_W'(TICK_CYCLES - 1)) begin
      count_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + CNT_W'(1);
      tick_reg <= 1'b0;
    end
  end

  assign tickBus.tick = tick_reg;

endmodule

// File: src/cct_calendar.sv
// Calendar clock: time and date counts, byte registers and one-second trim
// Summary of operation
// - Seconds, minutes wrap 59 to 00, carry
// - Hours wrap 23 to 00, carry to day
// - Weekday counts 1 to 7, daily, wraps
// - Date 1-31, month 1-12, eight-bit year
// - Year 00 counts as a leap year
// - Two write-only pulse bits, no stored value
// - Pulse adds or drops one second next tick
// - Request held until next tick, any width
module cct_calendar
  import cct_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic secTick
);

  cct_tick_if tickBus ();

  cct_time_t time_reg;
  cct_time_t time_next;
  cct_time_t stepped;
  cct_trim_state_t trimState_reg;
  cct_trim_state_t trimState_next;
  logic pendInc_reg;
  logic pendDec_reg;
  logic [7:0] rdData_reg;
  logic [7:0] rdMux;
  logic tick;
  logic trimWr;
  logic incReq;
  logic decReq;
  logic takeInc;
  logic takeDec;
  logic stepUpEn;
  logic stepDnEn;

  // ==========================================================================
  // Seconds timebase
  cct_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tickBus(tickBus)
  );

  assign tick = tickBus.tick;
  assign secTick = tick;

  // ==========================================================================
  // Month length for a given month and year
  function automatic logic [4:0] monthLen(input logic [3:0] mo, input logic [7:0] yr);
    logic [4:0] len;
    len = LEN_31;
    if (mo == MO_FEB) begin
      len = (yr[1:0] == 2'h0) ? LEN_29 : LEN_28;
    end else if (mo == MO_APR || mo == MO_JUN || mo == MO_SEP || mo == MO_NOV) begin
      len = LEN_30;
    end
    return len;
  endfunction

  // ==========================================================================
  // One second forward with the full carry chain
  function automatic cct_time_t stepUp(input cct_time_t t);
    cct_time_t n;
    n = t;
    if (t.sec >= SEC_MAX) begin
      n.sec = '0;
      if (t.min >= MIN_MAX) begin
        n.min = '0;
        if (t.hr >= HR_MAX) begin
          n.hr = '0;
          if (t.wday >= WDAY_MAX || t.wday < WDAY_MIN) begin
            n.wday = WDAY_MIN;
          end else begin
            n.wday = t.wday + 3'h1;
          end
          if (t.date >= monthLen(t.mo, t.yr)) begin
            n.date = DATE_MIN;
            if (t.mo >= MO_MAX) begin
              n.mo = MO_MIN;
              n.yr = t.yr + 8'h01;
            end else begin
              n.mo = t.mo + 4'h1;
            end
          end else begin
            n.date = t.date + 5'h01;
          end
        end else begin
          n.hr = t.hr + 5'h01;
        end
      end else begin
        n.min = t.min + 6'h01;
      end
    end else begin
      n.sec = t.sec + 6'h01;
    end
    return n;
  endfunction

  // ==========================================================================
  // One second backward with the full borrow chain
  function automatic cct_time_t stepDown(input cct_time_t t);
    cct_time_t n;
    n = t;
    if (t.sec == '0) begin
      n.sec = SEC_MAX;
      if (t.min == '0) begin
        n.min = MIN_MAX;
        if (t.hr == '0) begin
          n.hr = HR_MAX;
          if (t.wday <= WDAY_MIN || t.wday > WDAY_MAX) begin
            n.wday = WDAY_MAX;
          end else begin
            n.wday = t.wday - 3'h1;
          end
          if (t.date <= DATE_MIN) begin
            if (t.mo <= MO_MIN || t.mo > MO_MAX) begin
              n.mo = MO_MAX;
              n.yr = t.yr - 8'h01;
            end else begin
              n.mo = t.mo - 4'h1;
            end
            n.date = monthLen(n.mo, n.yr);
          end else begin
            n.date = t.date - 5'h01;
          end
        end else begin
          n.hr = t.hr - 5'h01;
        end
      end else begin
        n.min = t.min - 6'h01;
      end
    end else begin
      n.sec = t.sec - 6'h01;
    end
    return n;
  endfunction

  // ==========================================================================
  // Trim request decode; a write with both bits set is dropped
  assign trimWr = regWrEn && (regAddr == ADDR_TRIM);
  assign incReq = trimWr && regWrData[TRIM_INC_BIT] && !regWrData[TRIM_DEC_BIT];
  assign decReq = trimWr && regWrData[TRIM_DEC_BIT] && !regWrData[TRIM_INC_BIT];
  assign takeInc = tick && pendInc_reg;
  assign takeDec = tick && pendDec_reg && !pendInc_reg;

  // Pending trim flags: a new request wins over the clear at the tick
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pendInc_reg <= 1'b0;
      pendDec_reg <= 1'b0;
    end else begin
      if (incReq) begin
        pendInc_reg <= 1'b1;
      end else if (takeInc) begin
        pendInc_reg <= 1'b0;
      end
      if (decReq) begin
        pendDec_reg <= 1'b1;
      end else if (takeDec) begin
        pendDec_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Trim sequencer: extra step in the cycle after the regular tick
  always_comb begin
    trimState_next = trimState_reg;
    case (trimState_reg)
      CCT_TRIM_IDLE: begin
        if (takeInc) begin
          trimState_next = CCT_TRIM_UP;
        end else if (takeDec) begin
          trimState_next = CCT_TRIM_DN;
        end
      end
      CCT_TRIM_UP: begin
        trimState_next = CCT_TRIM_IDLE;
      end
      CCT_TRIM_DN: begin
        trimState_next = CCT_TRIM_IDLE;
      end
      default: begin
        trimState_next = CCT_TRIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trimState_reg <= CCT_TRIM_IDLE;
    end else begin
      trimState_reg <= trimState_next;
    end
  end

  assign stepUpEn = tick || (trimState_reg == CCT_TRIM_UP);
  assign stepDnEn = !tick && (trimState_reg == CCT_TRIM_DN);

  // ==========================================================================
  // Count update: step first, then a software write overrides its field
  always_comb begin
    if (stepUpEn) begin
      stepped = stepUp(time_reg);
    end else if (stepDnEn) begin
      stepped = stepDown(time_reg);
    end else begin
      stepped = time_reg;
    end
    time_next = stepped;
    if (regWrEn) begin
      if (regAddr == ADDR_SEC) begin
        time_next.sec = regWrData[SEC_W-1:0];
      end else if (regAddr == ADDR_MIN) begin
        time_next.min = regWrData[MIN_W-1:0];
      end else if (regAddr == ADDR_HR) begin
        time_next.hr = regWrData[HR_W-1:0];
      end else if (regAddr == ADDR_WDAY) begin
        time_next.wday = regWrData[WDAY_W-1:0];
      end else if (regAddr == ADDR_DATE) begin
        time_next.date = regWrData[DATE_W-1:0];
      end else if (regAddr == ADDR_MO) begin
        time_next.mo = regWrData[MO_W-1:0];
      end else if (regAddr == ADDR_YR) begin
        time_next.yr = regWrData[YR_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      time_reg <= '{yr: RST_YR, mo: RST_MO, date: RST_DATE, wday: RST_WDAY,
                    hr: RST_HR, min: RST_MIN, sec: RST_SEC};
    end else begin
      time_reg <= time_next;
    end
  end

  // ==========================================================================
  // Read path: trim register and unmapped addresses read as zero
  always_comb begin
    rdMux = 8'h00;
    if (regAddr == ADDR_SEC) begin
      rdMux = {2'h0, time_reg.sec};
    end else if (regAddr == ADDR_MIN) begin
      rdMux = {2'h0, time_reg.min};
    end else if (regAddr == ADDR_HR) begin
      rdMux = {3'h0, time_reg.hr};
    end else if (regAddr == ADDR_WDAY) begin
      rdMux = {5'h00, time_reg.wday};
    end else if (regAddr == ADDR_DATE) begin
      rdMux = {3'h0, time_reg.date};
    end else if (regAddr == ADDR_MO) begin
      rdMux = {4'h0, time_reg.mo};
    end else if (regAddr == ADDR_YR) begin
      rdMux = time_reg.yr;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= 8'h00;
    end else if (regRdEn) begin
      rdData_reg <= rdMux;
    end else begin
      rdData_reg <= 8'h00;
    end
  end

  assign regRdData = rdData_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic dayRoll;
  assign dayRoll = tick && !regWrEn && time_reg.sec == SEC_MAX &&
                   time_reg.min == MIN_MAX && time_reg.hr == HR_MAX;

  sec_write_load_a: assert property (
    regWrEn && regAddr == ADDR_SEC |=> time_reg.sec == $past(regWrData[5:0]))
    else $error("seconds write not loaded");

  hour_read_back_a: assert property (
    regRdEn && regAddr == ADDR_HR |=> regRdData == {3'h0, $past(time_reg.hr)})
    else $error("hours read mismatch");

  sec_carry_min_a: assert property (
    tick && !regWrEn && time_reg.sec == SEC_MAX && time_reg.min < MIN_MAX
    |=> time_reg.sec == 6'h00 && time_reg.min == $past(time_reg.min) + 6'h01)
    else $error("seconds wrap or carry wrong");

  hour_wrap_a: assert property (
    dayRoll |=> time_reg.hr == 5'h00 && time_reg.min == 6'h00)
    else $error("hours wrap wrong");

  wday_wrap_a: assert property (
    dayRoll && time_reg.wday == WDAY_MAX |=> time_reg.wday == WDAY_MIN)
    else $error("weekday wrap wrong");

  year_carry_a: assert property (
    dayRoll && time_reg.mo == MO_MAX && time_reg.date == LEN_31
    |=> time_reg.mo == MO_MIN && time_reg.date == DATE_MIN &&
        time_reg.yr == $past(time_reg.yr) + 8'h01)
    else $error("month or year carry wrong");

  leap_feb_a: assert property (
    dayRoll && time_reg.mo == MO_FEB && time_reg.date == LEN_28 && time_reg.yr[1:0] == 2'h0
    |=> time_reg.date == LEN_29)
    else $error("leap February lost its 29th");

  trim_no_store_a: assert property (
    trimWr && !stepUpEn && !stepDnEn |=> time_reg == $past(time_reg))
    else $error("trim write changed the counts");

  trim_hold_a: assert property (
    pendInc_reg && !tick |=> pendInc_reg)
    else $error("pending increment lost before tick");

  trim_inc_apply_a: assert property (
    tick && pendInc_reg && trimState_reg == CCT_TRIM_IDLE && time_reg.sec < 6'h3A &&
    !regWrEn ##1 !regWrEn |=> time_reg.sec == $past(time_reg.sec, 2) + 6'h02)
    else $error("increment trim not applied");

  trim_dec_apply_a: assert property (
    tick && !pendInc_reg && pendDec_reg && trimState_reg == CCT_TRIM_IDLE &&
    !regWrEn ##1 !regWrEn |=> time_reg == $past(time_reg, 2))
    else $error("decrement trim not applied");

  inc_trim_c: cover property (takeInc ##1 trimState_reg == CCT_TRIM_UP);
  dec_borrow_c: cover property (stepDnEn && time_reg.sec == 6'h00);
  year_roll_c: cover property (dayRoll && time_reg.mo == MO_MAX && time_reg.date == LEN_31);
  leap_day_c: cover property (dayRoll && time_reg.mo == MO_FEB && time_reg.date == LEN_29);

endmodule

// File: verif/cct_calendar_tb.sv
// Self-checking testbench of the calendar clock with one-second trim
module cct_calendar_tb
  import cct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Settings and signals
  localparam int unsigned TICKS = 20;
  localparam int TIMEOUT = 4000;
  logic core_clk;
  logic rst;
  logic [15:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regRdData;
  logic secTick;
  int errorCnt = 0;
  int checksDone = 0;
  int cycleCnt = 0;
  logic [7:0] rdVal;
  logic [15:0] gap;

  // Rows hold {year, month, date, weekday, hours, minutes, seconds}, one byte each
  logic [55:0] rowIn [8] = '{56'h10_0C_1F_07_17_3B_3B, 56'h00_02_1C_03_17_3B_3B,
    56'h04_02_1D_05_17_3B_3B, 56'h05_02_1C_02_17_3B_3B, 56'h05_04_1E_01_17_3B_3B,
    56'h05_01_1E_01_17_3B_3B, 56'h05_06_0A_04_0A_3B_3B, 56'h05_06_0A_04_00_00_3A};
  logic [55:0] rowOut [8] = '{56'h11_01_01_01_00_00_00, 56'h00_02_1D_04_00_00_00,
    56'h04_03_01_06_00_00_00, 56'h05_03_01_03_00_00_00, 56'h05_05_01_02_00_00_00,
    56'h05_01_1F_02_00_00_00, 56'h05_06_0A_04_0B_00_00, 56'h05_06_0A_04_00_00_3B};

  // ==========================================================================
  // Design under test with a short second
  cct_calendar #(.TICK_CYCLES(TICKS)) cct_calendar_i (
    .core_clk(core_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .secTick(secTick)
  );

  // Clock generator
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Bus and checking tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle; strobes stay until the next call changes them
  task automatic bus(input logic we, input logic re, input logic [15:0] a, input logic [7:0] d);
    regWrEn <= we;
    regRdEn <= re;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
  endtask

  // Read strobe, then sample the data in the following cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    bus(1'b0, 1'b1, a, 8'h00);
    #1;
    v = regRdData;
  endtask

  task automatic idle();
    bus(1'b0, 1'b0, ADDR_SEC, 8'h00);
  endtask

  // Returns at the edge that ends a tick cycle
  task automatic syncTick();
    do @(negedge core_clk); while (secTick !== 1'b1);
    @(posedge core_clk);
  endtask

  task automatic setTime(input logic [55:0] t);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, 1'b0, ADDR_SEC + 16'(i), t[8*i +: 8]);
    end
    idle();
  endtask

  // Two idle cycles let a trim step land before the counts are read
  task automatic checkTime(input logic [55:0] exp);
    logic [7:0] v;
    idle();
    idle();
    for (int i = 0; i < 7; i++) begin
      rd(ADDR_SEC + 16'(i), v);
      check($sformatf("count byte %0d", i), {8'h00, v}, {8'h00, exp[8*i +: 8]});
    end
    idle();
  endtask

  // Verdict and end of run
  task automatic wrapUp();
    if (errorCnt == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cycle ceiling against a hang
  always @(posedge core_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == TIMEOUT) begin
      errorCnt++;
      wrapUp();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    checkTime(56'h00_01_01_01_00_00_00);
    // Row loop over carries and month lengths
    for (int r = 0; r < 8; r++) begin
      syncTick();
      setTime(rowIn[r]);
      syncTick();
      checkTime(rowOut[r]);
    end
    // Trim register reads zero, unmapped reads zero, data stands one cycle
    rd(ADDR_TRIM, rdVal);
    check("trim read", {8'h00, rdVal}, 16'h0000);
    rd(16'h2014, rdVal);
    check("unmapped read", {8'h00, rdVal}, 16'h0000);
    rd(ADDR_SEC, rdVal);
    idle();
    #1;
    check("read data release", {8'h00, regRdData}, 16'h0000);
    // Upper bits dropped, unmapped write ignored
    syncTick();
    bus(1'b1, 1'b0, ADDR_SEC, 8'hC5);
    bus(1'b1, 1'b0, 16'h201D, 8'h33);
    rd(ADDR_SEC, rdVal);
    check("seconds field", {8'h00, rdVal}, 16'h0005);
    idle();
    // Tick spacing
    syncTick();
    gap = 16'h0000;
    do begin
      @(negedge core_clk);
      gap++;
    end while (secTick !== 1'b1 && gap < 16'h0100);
    check("tick spacing", gap, 16'(TICKS));
    @(negedge core_clk);
    check("tick width", {15'h0000, secTick}, 16'h0000);
    // Plus one second, held early until the tick, then consumed
    syncTick();
    setTime(56'h00_01_01_01_00_00_0A);
    bus(1'b1, 1'b0, ADDR_TRIM, 8'h01);
    idle();
    syncTick();
    checkTime(56'h00_01_01_01_00_00_0C);
    syncTick();
    checkTime(56'h00_01_01_01_00_00_0D);
    // Minus one second across every boundary, applied at the next tick
    syncTick();
    setTime(56'h10_0C_1F_07_17_3B_3B);
    bus(1'b1, 1'b0, ADDR_TRIM, 8'h02);
    idle();
    syncTick();
    checkTime(56'h10_0C_1F_07_17_3B_3B);
    // Both trim bits at once are refused
    syncTick();
    setTime(56'h00_01_01_01_00_00_0A);
    bus(1'b1, 1'b0, ADDR_TRIM, 8'h03);
    idle();
    syncTick();
    checkTime(56'h00_01_01_01_00_00_0B);
    // Reset in mid-run drops a pending trim and restarts the divider
    repeat (2) syncTick();
    bus(1'b1, 1'b0, ADDR_TRIM, 8'h01);
    rst <= 1'b1;
    idle();
    idle();
    rst <= 1'b0;
    checkTime(56'h00_01_01_01_00_00_00);
    syncTick();
    checkTime(56'h00_01_01_01_00_00_01);
    wrapUp();
  end
endmodule
